//--- common/arcu_pkg.sv
// constants, field layouts and mode codes of the result computation unit
// assumes a 32-bit ahb-lite register bus and a 16-bit converter result
package arcu_pkg;
    // mode codes of the computation mode select field
    typedef enum logic [2:0] {
        MODE_BASIC = 3'b000,
        MODE_ACCUM = 3'b001,
        MODE_AVG = 3'b010,
        MODE_BURST = 3'b011,
        MODE_LPF = 3'b100
    } arcu_mode_t;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_REPEAT = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [7:0] OFS_PREV = 8'h10;
    localparam logic [7:0] OFS_ACC = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_FILTER = 8'h1c;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DOUBLE_SAMPLE_ENABLE_BIT = 3;
    localparam int CTRL_PREVIOUS_STORE_SELECT_BIT = 4;
    localparam int CTRL_SHIFT_LSB = 8;
    localparam int CTRL_CLEAR_BIT = 16;
    localparam int CTRL_START_BIT = 17;
    localparam int CTRL_RCSEL_BIT = 18;

    // status register fields
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_TEST_BIT = 2;
    localparam int STAT_CLRBUSY_BIT = 3;
    localparam int STAT_BURST_BIT = 4;

    // widths and limits
    localparam int RES_W = 16;
    localparam int ACC_W = 19;
    localparam int SUM_W = 21;
    localparam int CNT_W = 8;
    localparam int FILT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic signed [SUM_W-1:0] ACC_MAX = 21'h03ffff;
    localparam logic signed [SUM_W-1:0] ACC_MIN = 21'h1c0000;

    // clear timing on the rc oscillator
    localparam logic [2:0] CLR_RC_CYCLES = 3'h5;

    // reset values
    localparam logic [CNT_W-1:0] RPT_RESET = 8'h00;
    localparam logic [2:0] SHIFT_RESET = 3'h0;
endpackage

//--- rtl/arcu_top.sv
// result computation unit: accumulator, counter, filter and test scheduling
// assumes conversion results and external triggers arrive on core_clk,
// and the rc oscillator level arrives asynchronously
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module arcu_top (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // converter core side
    input wire logic convValid,
    input wire logic [arcu_pkg::RES_W-1:0] convData,
    input wire logic extTrig,
    input wire logic rcOsc,
    output logic startConv,
    output logic thresholdTest,
    output logic conversionDoneFlag,
    output logic accumulateOverflowFlag
);
    import arcu_pkg::*;

    typedef struct packed {
        arcu_mode_t mode;
        logic double_sample_enable;
        logic previous_store_select;
        logic [2:0] shift;
        logic rcSel;
        logic clrReq;
        logic [2:0] rcCnt;
        logic [CNT_W-1:0] rpt;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] prev;
        logic [ACC_W-1:0] acc;
        logic [CNT_W-1:0] cnt;
        logic [FILT_W-1:0] filt;
        logic ovf;
        logic done;
        logic testDue;
        logic dsPhase;
        logic burstRun;
        logic startConv;
        logic testPulse;
        logic rcSync1;
        logic rcSync2;
        logic rcLast;
        logic busWr;
        logic rdPend;
        logic [7:0] busAddr;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } arcu_state_t;

    arcu_state_t s;
    arcu_state_t next_s;

    logic swStart;
    logic trig;
    logic rcEdge;
    logic second;
    logic [CNT_W-1:0] newCnt;
    logic ovfEv;
    logic signed [SUM_W-1:0] samp;
    logic signed [SUM_W-1:0] accExt;
    logic signed [SUM_W-1:0] sum;
    logic signed [SUM_W-1:0] fsh;
    logic [31:0] rdMux;

    // register read view, built from the settled state
    always_comb begin
        rdMux = 32'h00000000;
        case (s.busAddr)
            OFS_CTRL: begin
                rdMux[CTRL_MODE_LSB +: 3] = s.mode;
                rdMux[CTRL_DOUBLE_SAMPLE_ENABLE_BIT] = s.double_sample_enable;
                rdMux[CTRL_PREVIOUS_STORE_SELECT_BIT] = s.previous_store_select;
                rdMux[CTRL_SHIFT_LSB +: 3] = s.shift;
                rdMux[CTRL_CLEAR_BIT] = s.clrReq;
                rdMux[CTRL_RCSEL_BIT] = s.rcSel;
            end
            OFS_STATUS: begin
                rdMux[STAT_OVF_BIT] = s.ovf;
                rdMux[STAT_DONE_BIT] = s.done;
                rdMux[STAT_TEST_BIT] = s.testDue;
                rdMux[STAT_CLRBUSY_BIT] = s.clrReq;
                rdMux[STAT_BURST_BIT] = s.burstRun;
            end
            OFS_REPEAT: rdMux[CNT_W-1:0] = s.rpt;
            OFS_RESULT: rdMux[RES_W-1:0] = s.result;
            OFS_PREV: rdMux[RES_W-1:0] = s.prev;
            OFS_ACC: rdMux[23:0] = {{(24-ACC_W){s.acc[ACC_W-1]}}, s.acc};
            OFS_COUNT: rdMux[CNT_W-1:0] = s.cnt;
            OFS_FILTER: rdMux[FILT_W-1:0] = s.filt;
            default: rdMux = 32'h00000000;
        endcase
    end

    // next-state logic; later sections override earlier, so events beat clears
    always_comb begin
        next_s = s;
        next_s.startConv = 1'b0;
        next_s.testPulse = 1'b0;
        swStart = 1'b0;
        samp = '0;
        accExt = '0;
        sum = '0;
        fsh = '0;
        ovfEv = 1'b0;
        newCnt = s.cnt;
        second = 1'b0;

        // rc oscillator sync; edge taken from the second stage only
        next_s.rcSync1 = rcOsc;
        next_s.rcSync2 = s.rcSync1;
        next_s.rcLast = s.rcSync2;
        rcEdge = s.rcSync2 & ~s.rcLast;

        // bus data phase of a write
        if (s.busWr) begin
            case (s.busAddr)
                OFS_CTRL: begin
                    next_s.mode = arcu_mode_t'(hwdata[CTRL_MODE_LSB +: 3]);
                    next_s.double_sample_enable = hwdata[CTRL_DOUBLE_SAMPLE_ENABLE_BIT];
                    next_s.previous_store_select = hwdata[CTRL_PREVIOUS_STORE_SELECT_BIT];
                    next_s.shift = hwdata[CTRL_SHIFT_LSB +: 3];
                    next_s.rcSel = hwdata[CTRL_RCSEL_BIT];
                    if (hwdata[CTRL_CLEAR_BIT]) begin
                        next_s.clrReq = 1'b1;
                    end
                    swStart = hwdata[CTRL_START_BIT];
                end
                OFS_STATUS: begin
                    // write one to clear; hardware sets below still win
                    if (hwdata[STAT_DONE_BIT]) begin
                        next_s.done = 1'b0;
                    end
                    if (hwdata[STAT_TEST_BIT]) begin
                        next_s.testDue = 1'b0;
                    end
                end
                OFS_REPEAT: next_s.rpt = hwdata[CNT_W-1:0];
                default: next_s.busWr = 1'b0;
            endcase
        end

        // bus read answer after one wait state
        next_s.busWr = 1'b0;
        if (s.rdPend) begin
            next_s.hrdata = rdMux;
            next_s.hreadyout = 1'b1;
            next_s.rdPend = 1'b0;
        end

        // bus address phase
        if (hsel && htrans[1] && hready && s.hreadyout) begin
            next_s.busAddr = {haddr[7:2], 2'b00};
            if (hwrite) begin
                next_s.busWr = 1'b1;
            end else begin
                next_s.rdPend = 1'b1;
                next_s.hreadyout = 1'b0;
            end
        end

        // accumulator clear, five rc edges when on the rc oscillator
        if (s.clrReq) begin
            if (!s.rcSel || (rcEdge && s.rcCnt == CLR_RC_CYCLES - 3'h1)) begin
                next_s.acc = '0;
                next_s.cnt = '0;
                next_s.ovf = 1'b0;
                // a request written in the completing cycle stays pending, set wins
                next_s.clrReq = s.busWr && s.busAddr == OFS_CTRL && hwdata[CTRL_CLEAR_BIT];
                next_s.rcCnt = 3'h0;
            end else if (rcEdge) begin
                next_s.rcCnt = s.rcCnt + 3'h1;
            end
        end

        // trigger: software start or external event
        // a start written together with a new mode acts in that new mode
        trig = swStart | extTrig;
        if (trig) begin
            next_s.startConv = 1'b1;
            if (next_s.mode == MODE_AVG && s.cnt >= s.rpt) begin
                next_s.acc = '0;
                next_s.cnt = '0;
            end
            if (next_s.mode == MODE_BURST) begin
                next_s.acc = '0;
                next_s.cnt = '0;
                next_s.burstRun = 1'b1;
            end
        end

        // completed conversion
        if (convValid) begin
            // pair is complete on the single sample or the second of two
            second = !s.double_sample_enable || s.dsPhase;
            next_s.dsPhase = s.double_sample_enable ? ~s.dsPhase : 1'b0;
            next_s.result = convData;
            if (s.previous_store_select) begin
                next_s.prev = s.result;
            end
            if (s.double_sample_enable) begin
                samp = $signed({{(SUM_W-RES_W){1'b0}}, convData})
                    - $signed({{(SUM_W-RES_W){1'b0}}, s.result});
            end else begin
                samp = $signed({{(SUM_W-RES_W){1'b0}}, convData});
            end
            accExt = $signed({{(SUM_W-ACC_W){next_s.acc[ACC_W-1]}}, next_s.acc});
            newCnt = (next_s.cnt == CNT_MAX) ? next_s.cnt : next_s.cnt + 8'h01;
            if (s.mode != MODE_BASIC && second) begin
                if (s.mode == MODE_LPF) begin
                    sum = accExt + samp - (accExt >>> s.shift);
                end else begin
                    sum = accExt + samp;
                end
                ovfEv = (sum > ACC_MAX) || (sum < ACC_MIN);
                next_s.acc = sum[ACC_W-1:0];
                next_s.cnt = newCnt;
                // scaling or averaging by the shift field
                fsh = $signed({{(SUM_W-ACC_W){sum[ACC_W-1]}}, sum[ACC_W-1:0]})
                    >>> s.shift;
                next_s.filt = fsh[FILT_W-1:0];
                if (fsh[SUM_W-1:FILT_W-1] != {(SUM_W-FILT_W+1){fsh[SUM_W-1]}}) begin
                    ovfEv = 1'b1;
                end
                if (ovfEv) begin
                    next_s.ovf = 1'b1;
                end
            end
            // done flag: basic waits for the whole pair
            if (s.mode != MODE_BASIC || second) begin
                next_s.done = 1'b1;
            end
            // threshold test scheduling
            if (second) begin
                case (s.mode)
                    MODE_BASIC: next_s.testPulse = 1'b1;
                    MODE_ACCUM: next_s.testPulse = 1'b1;
                    MODE_AVG: next_s.testPulse = (newCnt >= s.rpt);
                    MODE_BURST: next_s.testPulse = (newCnt >= s.rpt);
                    MODE_LPF: next_s.testPulse = (newCnt >= s.rpt);
                    default: next_s.testPulse = 1'b0;
                endcase
            end
            if (next_s.testPulse) begin
                next_s.testDue = 1'b1;
            end
            // burst keeps requesting conversions until the target
            if (s.burstRun && s.mode == MODE_BURST) begin
                if (!second || newCnt < s.rpt) begin
                    next_s.startConv = 1'b1;
                end else begin
                    next_s.burstRun = 1'b0;
                end
            end
        end
        if (next_s.mode != MODE_BURST) begin
            next_s.burstRun = 1'b0;
        end
    end

    // state register, frozen while the clock enable is low; reset still loads regardless of it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
            s.mode <= MODE_BASIC;
            s.shift <= SHIFT_RESET;
            s.rpt <= RPT_RESET;
            s.hreadyout <= 1'b1;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign startConv = s.startConv;
    assign thresholdTest = s.testPulse;
    assign conversionDoneFlag = s.done;
    assign accumulateOverflowFlag = s.ovf;
endmodule

`default_nettype wire

//--- tb/arcu_checker.sv
// port-level assertions of the result computation unit
// assumes it is bound to arcu_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module arcu_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // converter side
    input wire logic convValid,
    input wire logic extTrig,
    input wire logic startConv,
    input wire logic thresholdTest,
    input wire logic conversionDoneFlag,
    input wire logic accumulateOverflowFlag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // a transfer counts only when both readies are high
    sequence take_s(w);
        clkEn && hsel && htrans[1] && hready && hreadyout && hwrite == w;
    endsequence
    sequence one_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    rd_one_wait_a: assert property (take_s(1'b0) |=> one_wait_s) else $error("read wait wrong");
    wr_no_wait_a: assert property (take_s(1'b1) |=> hreadyout) else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
    reset_quiet_a: assert property ($fell(rst) |-> hreadyout && !startConv && !thresholdTest
        && !conversionDoneFlag && !accumulateOverflowFlag) else $error("outputs not at reset");
    trig_start_a: assert property (clkEn && extTrig |=> startConv) else $error("no start");
    // software start shows two edges after its address phase
    start_cause_a: assert property (startConv |-> $past(extTrig) || $past(convValid)
        || $past(clkEn && hsel && htrans[1] && hready && hreadyout && hwrite, 2))
        else $error("start without cause");
    test_cause_a: assert property (thresholdTest |-> $past(convValid)) else $error("stray test");
    done_cause_a: assert property ($rose(conversionDoneFlag) |-> $past(convValid))
        else $error("stray done");
    ovf_cause_a: assert property ($rose(accumulateOverflowFlag) |-> $past(convValid))
        else $error("stray overflow");
endmodule
bind arcu_top arcu_checker arcu_checker_i (.core_clk, .rst, .clkEn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .convValid, .extTrig, .startConv, .thresholdTest,
    .conversionDoneFlag, .accumulateOverflowFlag);
`default_nettype wire

//--- tb/arcu_conv_model.sv
// converter core stand-in: answers each startConv after a latency set by the bench
// assumes startConv is a one-cycle pulse and no request arrives while busy
`timescale 1ns/1ps
`default_nettype none
module arcu_conv_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request, latency and sample to return
    input wire logic startConv,
    input wire logic [3:0] lat,
    input wire logic [15:0] smp,
    // result
    output logic convValid,
    output logic [15:0] convData
);
    int cnt = 0;
    logic [15:0] last = 16'h0000;
    // data outside the valid cycle is the inverse of the last, so stale reads show
    always @(posedge core_clk) begin
        convValid <= 1'b0;
        convData <= ~last;
        if (rst) begin
            cnt <= 0;
        end else if (cnt == 1) begin
            convValid <= 1'b1;
            convData <= smp;
            last <= smp;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (startConv) begin
            cnt <= int'(lat);
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_arcu_top.sv
// register-level bench of the result computation unit
// assumes a 40 MHz core clock and the converter stand-in on the result side
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_arcu_top;
    import arcu_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic extTrig = 1'b0;
    logic rcOsc = 1'b0;
    logic [15:0] smp = 16'h0;
    logic [3:0] lat = 4'h3;
    wire hreadyout, hresp, convValid, startConv, tTest, doneF, ovfF;
    wire [31:0] hrdata;
    wire [15:0] convData;
    logic [31:0] q;
    logic lastTest;
    int miscompares = 0;
    int samples_checked = 0;
    int rcN = 0;
    arcu_top arcu_top_i (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .convValid(convValid), .convData(convData), .extTrig(extTrig), .rcOsc(rcOsc),
        .startConv(startConv), .thresholdTest(tTest), .conversionDoneFlag(doneF),
        .accumulateOverflowFlag(ovfF));
    arcu_conv_model arcu_conv_model_i (.core_clk(core_clk), .rst(rst), .startConv(startConv),
        .lat(lat), .smp(smp), .convValid(convValid), .convData(convData));
    // core clock, and an rc oscillator far slower than it
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        forever #137 rcOsc = ~rcOsc;
    end
    always @(posedge rcOsc) rcN++;
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // bounded wait for a handshake sampled high: 0 ready, 1 result, 2 test
    task automatic wsig(input int k);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((k == 0 ? hreadyout : k == 1 ? convValid : tTest) !== 1'b1 && n < 300);
        if (n >= 300) begin
            miscompares++;
            close_out();
        end
    endtask
    // one ahb-lite single transfer; read data lands in q
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wsig(0);
        htrans <= 2'h0;
        hwdata <= d;
        wsig(0);
        q = hrdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // x: double_sample_enable, previous_store_select, clear, start, rc select from bit 0 up
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [2:0] s,
        input logic [4:0] x);
        return {13'h0, x[4], x[3], x[2], 5'h0, s, 3'h0, x[1], x[0], m};
    endfunction
    // external trigger, wait for the result, then take the test pulse
    task automatic trig(input logic [15:0] d);
        smp <= d;
        extTrig <= 1'b1;
        @(posedge core_clk);
        extTrig <= 1'b0;
        wsig(1);
        @(posedge core_clk);
        lastTest = tTest;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        chk(OFS_CTRL, 32'h0);
        chk(OFS_COUNT, 32'h0);
        xfer(1'b1, 8'h40, 32'hffffffff);
        chk(8'h40, 32'h0);
        // basic mode, double sampling: done and test wait for the pair
        xfer(1'b1, OFS_CTRL, ctl(MODE_BASIC, 3'h0, 5'h3));
        trig(16'h0032);
        `CHK({lastTest, doneF}, 2'b00)
        trig(16'h0050);
        `CHK({lastTest, doneF}, 2'b11)
        chk(OFS_PREV, 32'h32);
        chk(OFS_ACC, 32'h0);
        xfer(1'b1, OFS_STATUS, 32'h6);
        xfer(1'b1, OFS_CTRL, ctl(MODE_ACCUM, 3'h0, 5'h5));
        trig(16'h005a);
        `CHK(doneF, 1'b1)
        trig(16'h0064);
        chk(OFS_ACC, 32'ha);
        // long accumulation: counter saturates, then the sum overflows
        xfer(1'b1, OFS_CTRL, ctl(MODE_ACCUM, 3'h4, 5'h4));
        lat <= 4'h1;
        repeat (257) trig(16'd1000);
        chk(OFS_COUNT, 32'hff);
        chk(OFS_ACC, 32'h03ebe8);
        chk(OFS_FILTER, 32'h3ebe);
        `CHK(ovfF, 1'b0)
        repeat (6) trig(16'd1000);
        trig(16'h0);
        `CHK(ovfF, 1'b1)
        xfer(1'b1, OFS_CTRL, ctl(MODE_ACCUM, 3'h0, 5'h4));
        chk(OFS_CTRL, ctl(MODE_ACCUM, 3'h0, 5'h0));
        `CHK(ovfF, 1'b0)
        chk(OFS_COUNT, 32'h0);
        trig(16'd40000);
        `CHK(ovfF, 1'b1)
        // clear on the rc oscillator, launched well clear of an rc edge
        @(posedge rcOsc);
        repeat (4) @(posedge core_clk);
        xfer(1'b1, OFS_CTRL, ctl(MODE_AVG, 3'h1, 5'h14));
        rcN = 0;
        do xfer(1'b0, OFS_STATUS, 32'h0); while (q[STAT_CLRBUSY_BIT] !== 1'b0 && rcN < 9);
        `CHK(rcN, 5)
        `CHK(ovfF, 1'b0)
        xfer(1'b1, OFS_CTRL, ctl(MODE_AVG, 3'h1, 5'h0));
        xfer(1'b1, OFS_REPEAT, 32'h2);
        lat <= 4'h7;
        trig(16'd10);
        `CHK(lastTest, 1'b0)
        trig(16'd20);
        `CHK(lastTest, 1'b1)
        chk(OFS_FILTER, 32'hf);
        trig(16'd40);
        chk(OFS_ACC, 32'h28);
        // burst from one software start
        xfer(1'b1, OFS_REPEAT, 32'h3);
        smp <= 16'h7;
        xfer(1'b1, OFS_CTRL, ctl(MODE_BURST, 3'h0, 5'hc));
        wsig(2);
        chk(OFS_COUNT, 32'h3);
        chk(OFS_ACC, 32'h15);
        // low-pass: tests from the repeat target onward
        xfer(1'b1, OFS_CTRL, ctl(MODE_LPF, 3'h1, 5'h4));
        xfer(1'b1, OFS_REPEAT, 32'h2);
        trig(16'd100);
        `CHK(lastTest, 1'b0)
        trig(16'd100);
        `CHK(lastTest, 1'b1)
        trig(16'd100);
        `CHK(lastTest, 1'b1)
        chk(OFS_ACC, 32'haf);
        chk(OFS_FILTER, 32'h57);
        chk(OFS_COUNT, 32'h3);
        // frozen by the clock enable: a trigger is lost and state holds
        clkEn <= 1'b0;
        extTrig <= 1'b1;
        @(posedge core_clk);
        extTrig <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(startConv, 1'b0)
        clkEn <= 1'b1;
        chk(OFS_COUNT, 32'h3);
        close_out();
    end
endmodule
`default_nettype wire
